// ==== rtl/pwm_channel_pkg.sv ====
// constants shared by the pwm output channel
package pwm_channel_pkg;

    // register byte addresses on the avalon slave
    localparam logic [3:0] ADDR_TIMER_COUNT   = 4'h0;
    localparam logic [3:0] ADDR_PERIOD_LIMIT  = 4'h4;
    localparam logic [3:0] ADDR_TIMER_CONTROL = 4'h8;
    localparam logic [3:0] ADDR_DUTY_LOW      = 4'hC;
    localparam logic [4:0] ADDR_DUTY_SHADOW   = 5'h10;
    localparam logic [4:0] ADDR_CHAN_CONTROL  = 5'h14;
    localparam logic [4:0] ADDR_PIN_DIRECTION = 5'h18;

    // reset values
    localparam logic [7:0] RST_BYTE           = 8'h00;
    localparam logic [7:0] RST_PERIOD_LIMIT   = 8'hFF;
    localparam logic       RST_PIN_DIRECTION  = 1'b1;

    // timer control fields
    localparam int TCTL_PRESCALE_LO = 0;
    localparam int TCTL_RUN         = 2;
    localparam int TCTL_POST_LO     = 3;
    localparam logic [7:0] TCTL_MASK = 8'h7F;

    // channel control fields
    localparam int CCTL_MODE_LO  = 0;
    localparam int CCTL_FRAC_LO  = 4;
    localparam logic [7:0] CCTL_MASK = 8'h3F;
    // pwm operation selected by mode field 1100 or 1101, 1110, 1111
    localparam logic [1:0] MODE_PWM_TOP = 2'h3;

    // one instruction cycle is four core clocks
    localparam logic [1:0] QUARTER_LAST = 2'h3;
    localparam logic [3:0] PRESCALE_DIV16_LAST = 4'hF;
    localparam logic [3:0] PRESCALE_DIV4_LAST  = 4'h3;

endpackage : pwm_channel_pkg

// ==== rtl/pwm_output_channel.sv ====
// pwm output channel: period timer, prescaler, duty double-buffer, avalon slave
//
// Design decisions made here: the address map and the Avalon-MM slave port.
`timescale 1ns/10ps

// Summary of operation
// RULE1: period length comes from the period limit register written by software
// RULE2: timer equal to period limit clears on the next increment cycle
// RULE3: output goes high at each period start unless duty is zero
// RULE4: at rollover the duty byte and fraction bits load into the shadow
// RULE5: postscaler bits are stored only and never affect the period
// RULE6: duty is ten bits: low duty byte above control bits 5:4
// RULE7: duty writes take effect only after the current period ends
// RULE8: in pwm mode the shadow byte is read-only
// RULE9: shadow byte plus two-bit latch double-buffer the duty
// RULE10: output clears when latched duty equals timer with two fine bits
// RULE11: duty beyond the period never clears the output
// RULE12: prescaler divides by 1, 4 or 16 from two select bits
// RULE13: software programs period, duty, direction, prescaler, then pwm mode
// RULE14: unimplemented control bits read back as zero
// RULE15: writing zero to channel control forces the output latch low
// RULE16: mode field values 11xx select pwm operation
// RULE17: timer advances only while the run bit is set, on prescaled cycles
module pwm_output_channel
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             pwm_output_pin_o,
    output logic             pwm_output_pin_oe
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] period_timer_count_q;
    logic [7:0] period_limit_q;
    logic [7:0] period_timer_control_q;
    logic [7:0] duty_low_byte_q;
    logic [7:0] duty_shadow_byte_q;
    logic [7:0] channel_control_q;
    logic [1:0] frac_latch_q;
    logic       pin_direction_bit_q;
    logic [1:0] quarter_q;
    logic [3:0] prescale_q;
    logic       pwm_level_q;
    logic       ack_q;

    logic       wr_en;
    logic       rd_en;
    logic       pwm_mode;
    logic       inc_tick;
    logic       rollover;
    logic [9:0] fine_count;
    logic       duty_match;

    function automatic logic [7:0] byte_in(input logic [31:0] data);
        byte_in = data[7:0];
    endfunction

    // one wait state per access: waitrequest drops on the cycle after the request
    assign wr_en    = avs_write && ack_q == 1'b0 && avs_byteenable[0];
    assign rd_en    = avs_read && ack_q == 1'b0;
    assign pwm_mode = channel_control_q[pwm_channel_pkg::CCTL_MODE_LO+3 -: 2]
                      == pwm_channel_pkg::MODE_PWM_TOP; // [RULE16]

    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            ack_q           <= 1'b0;
            avs_waitrequest <= 1'b1;
        end
        else
        begin
            ack_q           <= (avs_read || avs_write) && ack_q == 1'b0;
            avs_waitrequest <= !((avs_read || avs_write) && ack_q == 1'b0);
        end
    end

    // ------------------------------------------------------------
    // prescaler and instruction-cycle divider
    // ------------------------------------------------------------
    // the quarter counter always runs, so it doubles as the fine bits at divide-by-one
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            quarter_q  <= 2'h0;
            prescale_q <= 4'h0;
        end
        else
        begin
            quarter_q <= quarter_q + 2'h1;
            if (!period_timer_control_q[pwm_channel_pkg::TCTL_RUN])
            begin
                prescale_q <= 4'h0;
            end
            else if (quarter_q == pwm_channel_pkg::QUARTER_LAST)
            begin
                prescale_q <= inc_tick ? 4'h0 : prescale_q + 4'h1; // [RULE17]
            end
        end
    end

    always_comb
    begin
        inc_tick = 1'b0;
        if (period_timer_control_q[pwm_channel_pkg::TCTL_RUN]
            && quarter_q == pwm_channel_pkg::QUARTER_LAST) // [RULE17]
        begin
            // postscale bits 6:3 deliberately unused here [RULE5]
            if (period_timer_control_q[pwm_channel_pkg::TCTL_PRESCALE_LO+1])
            begin
                inc_tick = prescale_q == pwm_channel_pkg::PRESCALE_DIV16_LAST; // [RULE12]
            end
            else if (period_timer_control_q[pwm_channel_pkg::TCTL_PRESCALE_LO])
            begin
                inc_tick = prescale_q[1:0] == pwm_channel_pkg::PRESCALE_DIV4_LAST[1:0]; // [RULE12]
            end
            else
            begin
                inc_tick = 1'b1; // [RULE12]
            end
        end
    end

    assign rollover = inc_tick && period_timer_count_q == period_limit_q; // [RULE1] [RULE2]

    // fine bits: quarter clock at divide-by-one, otherwise prescaler bits
    always_comb
    begin
        if (period_timer_control_q[pwm_channel_pkg::TCTL_PRESCALE_LO+1])
        begin
            fine_count = {period_timer_count_q, prescale_q[3:2]}; // [RULE10]
        end
        else if (period_timer_control_q[pwm_channel_pkg::TCTL_PRESCALE_LO])
        begin
            fine_count = {period_timer_count_q, prescale_q[1:0]}; // [RULE10]
        end
        else
        begin
            fine_count = {period_timer_count_q, quarter_q}; // [RULE10]
        end
    end

    // the pin flop also sees the match, so the pin drops on the edge that ends the matching cycle, with the latch
    // and a match in the last cycle of a period is not swallowed by the rollover
    assign duty_match = {duty_shadow_byte_q, frac_latch_q} == fine_count; // [RULE10]

    // ------------------------------------------------------------
    // timer and software registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            period_timer_count_q <= pwm_channel_pkg::RST_BYTE;
        end
        else if (wr_en && avs_address == {1'b0, pwm_channel_pkg::ADDR_TIMER_COUNT})
        begin
            period_timer_count_q <= byte_in(avs_writedata);
        end
        else if (rollover)
        begin
            period_timer_count_q <= 8'h00; // [RULE2]
        end
        else if (inc_tick)
        begin
            period_timer_count_q <= period_timer_count_q + 8'h01;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            period_limit_q         <= pwm_channel_pkg::RST_PERIOD_LIMIT;
            period_timer_control_q <= pwm_channel_pkg::RST_BYTE;
            duty_low_byte_q        <= pwm_channel_pkg::RST_BYTE;
            channel_control_q      <= pwm_channel_pkg::RST_BYTE;
            pin_direction_bit_q    <= pwm_channel_pkg::RST_PIN_DIRECTION;
        end
        else if (wr_en)
        begin
            if (avs_address == {1'b0, pwm_channel_pkg::ADDR_PERIOD_LIMIT})
            begin
                period_limit_q <= byte_in(avs_writedata); // [RULE1]
            end
            else if (avs_address == {1'b0, pwm_channel_pkg::ADDR_TIMER_CONTROL})
            begin
                period_timer_control_q <= byte_in(avs_writedata) & pwm_channel_pkg::TCTL_MASK; // [RULE14]
            end
            else if (avs_address == {1'b0, pwm_channel_pkg::ADDR_DUTY_LOW})
            begin
                duty_low_byte_q <= byte_in(avs_writedata); // [RULE7]
            end
            else if (avs_address == pwm_channel_pkg::ADDR_CHAN_CONTROL)
            begin
                channel_control_q <= byte_in(avs_writedata) & pwm_channel_pkg::CCTL_MASK; // [RULE14]
            end
            else if (avs_address == pwm_channel_pkg::ADDR_PIN_DIRECTION)
            begin
                pin_direction_bit_q <= avs_writedata[0];
            end
        end
    end

    // ------------------------------------------------------------
    // duty double-buffer
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            duty_shadow_byte_q <= pwm_channel_pkg::RST_BYTE;
            frac_latch_q       <= 2'h0;
        end
        else if (pwm_mode && rollover)
        begin
            duty_shadow_byte_q <= duty_low_byte_q; // [RULE4] [RULE6] [RULE9]
            // fraction bits go to the internal latch [RULE4] [RULE9]
            frac_latch_q       <= channel_control_q[pwm_channel_pkg::CCTL_FRAC_LO +: 2];
        end
        else if (!pwm_mode && wr_en && avs_address == pwm_channel_pkg::ADDR_DUTY_SHADOW)
        begin
            duty_shadow_byte_q <= byte_in(avs_writedata); // [RULE8]
        end
    end

    // ------------------------------------------------------------
    // output latch
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pwm_level_q <= 1'b0;
        end
        else if (wr_en && avs_address == pwm_channel_pkg::ADDR_CHAN_CONTROL
                 && byte_in(avs_writedata) == 8'h00)
        begin
            pwm_level_q <= 1'b0; // [RULE15]
        end
        else if (!pwm_mode)
        begin
            pwm_level_q <= 1'b0;
        end
        else if (rollover)
        begin
            // high unless the duty about to latch is zero [RULE3]
            pwm_level_q <= {duty_low_byte_q,
                            channel_control_q[pwm_channel_pkg::CCTL_FRAC_LO +: 2]} != 10'h000;
        end
        else if (duty_match)
        begin
            // a duty above the period never matches, so the pin stays high [RULE11]
            pwm_level_q <= 1'b0; // [RULE10]
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pwm_output_pin_o  <= 1'b0;
            pwm_output_pin_oe <= 1'b0;
        end
        else
        begin
            pwm_output_pin_o  <= pwm_level_q && !duty_match; // [RULE10]
            // pin drives only once software clears the direction bit [RULE13]
            pwm_output_pin_oe <= !pin_direction_bit_q;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            avs_readdata <= 32'h0000_0000;
        end
        else if (rd_en)
        begin
            if (avs_address == {1'b0, pwm_channel_pkg::ADDR_TIMER_COUNT})
                avs_readdata <= {24'h000000, period_timer_count_q};
            else if (avs_address == {1'b0, pwm_channel_pkg::ADDR_PERIOD_LIMIT})
                avs_readdata <= {24'h000000, period_limit_q};
            else if (avs_address == {1'b0, pwm_channel_pkg::ADDR_TIMER_CONTROL})
                avs_readdata <= {24'h000000, period_timer_control_q};
            else if (avs_address == {1'b0, pwm_channel_pkg::ADDR_DUTY_LOW})
                avs_readdata <= {24'h000000, duty_low_byte_q};
            else if (avs_address == pwm_channel_pkg::ADDR_DUTY_SHADOW)
                avs_readdata <= {24'h000000, duty_shadow_byte_q};
            else if (avs_address == pwm_channel_pkg::ADDR_CHAN_CONTROL)
                avs_readdata <= {24'h000000, channel_control_q};
            else if (avs_address == pwm_channel_pkg::ADDR_PIN_DIRECTION)
                avs_readdata <= {31'h00000000, pin_direction_bit_q};
            else
                avs_readdata <= 32'h0000_0000;
        end
    end

endmodule // pwm_output_channel

// ==== tb/pwm_load_model.sv ====
// load on the pwm pin: pull-down, counts high clocks and rise spacing
`timescale 1ns/10ps
module pwm_load_model
(
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic pin_o,
    input  wire logic pin_oe,
    output logic      level,
    output int        high_total,
    output int        rise_gap
);
    int   since_rise;
    logic level_q;
    // a released pin is pulled low by the load, never left at its last value
    assign level = pin_oe ? pin_o : 1'b0;
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            high_total <= 0;
            rise_gap   <= 0;
            since_rise <= 0;
            level_q    <= 1'b0;
        end
        else
        begin
            level_q    <= level;
            high_total <= high_total + int'(level);
            since_rise <= (level && !level_q) ? 1 : since_rise + 1;
            if (level && !level_q)
                rise_gap <= since_rise;
        end
    end
endmodule // pwm_load_model

// ==== tb/pwm_output_channel_monitor.sv ====
// port assertions for the pwm output channel
`timescale 1ns/10ps
module pwm_output_channel_checker
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        pwm_output_pin_o,
    input wire logic        pwm_output_pin_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    wire rd_ok = avs_read && !avs_waitrequest;
    wire wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
    property p_dir;
        wr_ok && avs_address == 5'h18 |=> pwm_output_pin_oe == !$past(avs_writedata[0]);
    endproperty
    chk_wait_single: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("waitrequest low too long");
    chk_wait_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("answer without request");
    chk_read_hold: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data moved without read");
    chk_read_upper: assert property (rd_ok |-> avs_readdata[31:8] == 24'h000000)
        else $error("upper read lanes not zero");
    chk_chan_reserved: assert property (rd_ok && avs_address == 5'h14 |-> avs_readdata[7:6] == 2'h0)
        else $error("channel control reserved bits set");
    chk_tctl_reserved: assert property (rd_ok && avs_address == 5'h08 |-> !avs_readdata[7])
        else $error("timer control bit 7 set");
    chk_dir_drive: assert property (p_dir)
        else $error("pin enable ignores direction");
    chk_zero_low: assert property (wr_ok && avs_address == 5'h14
        && avs_writedata[7:0] == 8'h00 |=> !pwm_output_pin_o [*2])
        else $error("pin not forced low");
    chk_reset_idle: assert property ($fell(reset) |-> avs_waitrequest && !pwm_output_pin_oe)
        else $error("outputs not idle after reset");
    cover property (pwm_output_pin_oe && $rose(pwm_output_pin_o));
    cover property (rd_ok && avs_address == 5'h10);
    cover property (wr_ok && avs_address == 5'h14);
endmodule // pwm_output_channel_checker

bind pwm_output_channel pwm_output_channel_checker u_pwm_output_channel_checker
(
    .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pwm_output_pin_o(pwm_output_pin_o), .pwm_output_pin_oe(pwm_output_pin_oe)
);

// ==== tb/pwm_output_channel_tb_top.sv ====
// self-checking bench for the pwm output channel
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
    $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module pwm_output_channel_tb_top;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        pwm_output_pin_o;
    logic        pwm_output_pin_oe;
    logic        load_level;
    logic [31:0] rd;
    logic [31:0] old;
    logic [7:0]  rst_tab [8] = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
    int          high_total, rise_gap, lim, duty, pre, ps, h0;
    int          n_errors = 0;
    int          checks = 0;
    int          seed = 92069;
    always #2 clk = ~clk;
    pwm_output_channel u_pwm_output_channel (.*);
    pwm_load_model u_pwm_load_model
    (
        .clk(clk), .reset(reset), .pin_o(pwm_output_pin_o), .pin_oe(pwm_output_pin_oe),
        .level(load_level), .high_total(high_total), .rise_gap(rise_gap)
    );
    // one avalon beat; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
                       input logic [3:0] be = 4'h1);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 40);
        `CHK("waitrequest", 1'b0, avs_waitrequest)
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // duty beyond the period keeps the pin high throughout
    function automatic int exp_high(int dt, int lm, int pr);
        if (dt > (lm + 1) * 4)
            return (lm + 1) * 4 * pr;
        return dt * pr;
    endfunction
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            bus(1'b0, 5'(i * 4), 8'h00);
            `CHK("reset value", {24'h0, rst_tab[i]}, rd)
        end
        bus(1'b1, 5'h08, 8'hFB);
        bus(1'b0, 5'h08, 8'h00);
        `CHK("timer control", 32'h7B, rd)
        bus(1'b1, 5'h04, 8'h55, 4'h0);
        bus(1'b1, 5'h14, 8'hFF);
        bus(1'b0, 5'h14, 8'h00);
        `CHK("channel control", 32'h3F, rd)
        bus(1'b1, 5'h10, 8'h5A);
        bus(1'b0, 5'h10, 8'h00);
        `CHK("shadow write", 32'h0, rd)
        bus(1'b0, 5'h04, 8'h00);
        `CHK("disabled lane", 32'hFF, rd)
        $display("test registers done");
        for (int k = 0; k < 6; k++)
        begin
            ps = k % 3;
            pre = (ps == 0) ? 1 : (ps == 1) ? 4 : 16;
            lim = 2 + ($unsigned($random(seed)) % 9);
            duty = 1 + ($unsigned($random(seed)) % ((lim + 1) * 4 - 1));
            if (k == 0)
                duty = 0;
            if (k == 1)
                duty = (lim + 1) * 4 + 3;
            bus(1'b1, 5'h14, 8'h00);
            bus(1'b1, 5'h08, 8'h00);
            bus(1'b1, 5'h00, 8'h00);
            bus(1'b1, 5'h04, 8'(lim));
            bus(1'b1, 5'h0C, 8'(duty >> 2));
            bus(1'b1, 5'h18, 8'h00);
            bus(1'b1, 5'h08, {1'b0, 4'($random(seed)), 1'b1, 2'(ps)});
            bus(1'b1, 5'h14, {2'h0, 2'(duty), 4'hC});
            repeat (3 * (lim + 1) * 4 * pre) @(posedge clk);
            h0 = high_total;
            repeat (2 * (lim + 1) * 4 * pre) @(posedge clk);
            `CHK("high time", 2 * exp_high(duty, lim, pre), high_total - h0)
            if (k > 1)
                `CHK("period", (lim + 1) * 4 * pre, rise_gap)
            bus(1'b0, 5'h10, 8'h00);
            `CHK("shadow", 32'(duty >> 2), rd)
        end
        $display("test waveforms done");
        @(posedge load_level);
        bus(1'b1, 5'h0C, 8'hA5);
        bus(1'b0, 5'h10, 8'h00);
        `CHK("shadow held", 32'(duty >> 2), rd)
        repeat ((lim + 1) * 64) @(posedge clk);
        bus(1'b0, 5'h10, 8'h00);
        `CHK("shadow loaded", 32'hA5, rd)
        $display("test double buffer done");
        bus(1'b1, 5'h14, 8'h00);
        repeat (3) @(posedge clk);
        `CHK("pin forced low", 1'b0, pwm_output_pin_o)
        bus(1'b1, 5'h08, 8'h00);
        bus(1'b0, 5'h00, 8'h00);
        old = rd;
        repeat (80) @(posedge clk);
        bus(1'b0, 5'h00, 8'h00);
        `CHK("stopped count", old, rd)
        bus(1'b1, 5'h18, 8'h01);
        repeat (3) @(posedge clk);
        `CHK("pin released", 1'b0, pwm_output_pin_oe)
        $display("test stop done");
        final_report();
    end
    initial
    begin
        repeat (60000) @(posedge clk);
        n_errors++;
        final_report();
    end
endmodule // pwm_output_channel_tb_top
